// File: rtl/ramp_if.sv
// Bundle between the soft-start top and its ramp sequencer.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
interface ramp_if #(parameter int W = 16) ();
  logic [W-1:0] period;
  logic [W-1:0] limit;
  ss_pkg::rate_t rate;
  logic start;
  logic [W-1:0] phase;
  logic cycle_end;
  logic [W-1:0] ramp;
  logic active;
  logic done;

  modport ctrl (input period, input limit, input rate, input start,
                output phase, output cycle_end, output ramp, output active, output done);
  modport user (output period, output limit, output rate, output start,
                input phase, input cycle_end, input ramp, input active, input done);
endinterface : ramp_if

// File: rtl/ss_defines.svh
// Constants for the fixed-duty channel soft-start block.
// Assumes a single 100 MHz clock; included by bare name.
//
// Contract
// R1 - With the primary edge-order bit set, drives 1, 2, 5 and 6 fall after they rise in every cycle of the soft start.
// R2 - The secondary edge-order bit counts only with the primary bit set: 0 makes drives 3, 4, 7 and 8 rise after falling, 1 makes them fall after rising.
// R3 - The output timing moves by one 40 ns step every 1, 2, 4 or 8 switching cycles, chosen by ramp field values 00, 01, 10 and 11.
// R4 - With global variation set, every output uses the variation computed from drive 2 and both group selects are ignored.
// R5 - With global variation clear, odd drives take their variation independently of even drives.
// R6 - Drive 2 variation is its fall time minus its rise time with the mode bit clear, and the switching period minus its rise time with it set.
// R7 - With global variation clear, the odd select picks the edges of drive 1 (0) or drive 3 (1) for drives 1, 3, 5 and 7.
// R8 - With global variation clear, the even select picks the edges of drive 2 (0) or drive 4 (1) for drives 2, 4, 6 and 8.
// R9 - The ramp steps from the start of soft start until the programmed edges are reached and then holds them with no further steps.
`ifndef SS_DEFINES_SVH
`define SS_DEFINES_SVH

`define SS_CFG_ADDR 16'hFE68
`define SS_STAT_ADDR 16'hFF00
`define SS_CFG_RESET 8'h00
`define SS_STAT_ACTIVE_BIT 0
`define SS_STAT_DONE_BIT 1

`define SS_STEP_NS 40
`define SS_CLK_PERIOD_NS 10
`define SS_STEP_TICKS ((`SS_STEP_NS + `SS_CLK_PERIOD_NS - 1) / `SS_CLK_PERIOD_NS)

`define SS_NUM_DRIVES 8
`define SS_GRP_A_MASK 8'h33
`define SS_ODD_MASK 8'h55
`define SS_IDX_D1 0
`define SS_IDX_D2 1
`define SS_IDX_D3 2
`define SS_IDX_D4 3

`endif

// File: rtl/ss_edge.sv
// One PWM drive: high between its rise and fall positions.
// Positions may wrap past the end of the switching cycle.
`timescale 1ns/1ps
module ss_edge #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timing
  input wire logic run,
  input wire logic [W-1:0] phase,
  input wire logic [W-1:0] rise,
  input wire logic [W-1:0] fall,
  // Drive
  output logic drive
);
  logic high;

  // Equal edges give zero on-time, not a full cycle
  assign high = (rise <= fall) ? ((phase >= rise) && (phase < fall))
                               : ((phase >= rise) || (phase < fall));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive <= 1'b0;
    end else begin
      drive <= run && high;
    end
  end
endmodule : ss_edge

// File: rtl/ss_fixed_duty_soft_start.sv
// Soft-start sequencing for the fixed-duty PWM channel.
// Assumes programmed edge positions and period come from logic on MCLK,
// in clock ticks, with every position below the period.
`timescale 1ns/1ps
`include "ss_defines.svh"
module ss_fixed_duty_soft_start #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Programmed timing
  input wire logic [W-1:0] SW_PERIOD,
  input wire logic [`SS_NUM_DRIVES*W-1:0] RISE_POS,
  input wire logic [`SS_NUM_DRIVES*W-1:0] FALL_POS,
  input wire logic SS_START,
  // Drives and status
  output logic [`SS_NUM_DRIVES-1:0] PWM_DRIVE,
  output logic SS_ACTIVE,
  output logic SS_DONE
);
  import ss_pkg::*;

  localparam int N = `SS_NUM_DRIVES;
  // Group masks indexed per drive; a bare literal cannot be bit-selected
  localparam logic [N-1:0] ODD_MASK = `SS_ODD_MASK;
  localparam logic [N-1:0] GRP_A_MASK = `SS_GRP_A_MASK;

  ss_pkg::cfg_t cfg_r;
  logic [7:0] rdata_r;
  logic [7:0] stat;
  logic [W-1:0] rise_a [N];
  logic [W-1:0] fall_a [N];
  logic [W-1:0] gap [N];
  logic [W-1:0] eff_rise_nxt [N];
  logic [W-1:0] eff_fall_nxt [N];
  logic [W-1:0] eff_rise_r [N];
  logic [W-1:0] eff_fall_r [N];
  logic [W-1:0] v2;
  logic [W-1:0] v_odd;
  logic [W-1:0] v_even;
  logic [W-1:0] shrink_odd;
  logic [W-1:0] shrink_even;
  logic run_r;

  ramp_if #(.W(W)) rif ();

  function automatic logic [W-1:0] wrap_add(input logic [W-1:0] a, input logic [W-1:0] b,
                                           input logic [W-1:0] p);
    logic [W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, p}) begin
      s = s - {1'b0, p};
    end
    return s[W-1:0];
  endfunction : wrap_add

  function automatic logic [W-1:0] wrap_sub(input logic [W-1:0] a, input logic [W-1:0] b,
                                           input logic [W-1:0] p);
    logic [W:0] s;
    s = {1'b0, a} + {1'b0, p} - {1'b0, b};
    if (s >= {1'b0, p}) begin
      s = s - {1'b0, p};
    end
    return s[W-1:0];
  endfunction : wrap_sub

  function automatic logic [W-1:0] sat_sub(input logic [W-1:0] a, input logic [W-1:0] b);
    return (a > b) ? a - b : '0;
  endfunction : sat_sub

  // High time from rise to the following fall, across the cycle end if needed
  function automatic logic [W-1:0] gap_of(input logic [W-1:0] r, input logic [W-1:0] f,
                                         input logic [W-1:0] p);
    return (f >= r) ? f - r : wrap_sub(f, r, p);
  endfunction : gap_of

  // Register writes
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cfg_r <= ss_pkg::cfg_t'(`SS_CFG_RESET);
    end else if (REG_WR && (REG_ADDR == `SS_CFG_ADDR)) begin
      cfg_r <= ss_pkg::cfg_t'(REG_WDATA);
    end
  end

  always_comb begin
    stat = 8'h00;
    stat[`SS_STAT_ACTIVE_BIT] = rif.active;
    stat[`SS_STAT_DONE_BIT] = rif.done;
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_r <= 8'h00;
    end else if (!REG_RD) begin
      rdata_r <= 8'h00;
    end else if (REG_ADDR == `SS_CFG_ADDR) begin
      rdata_r <= cfg_r;
    end else if (REG_ADDR == `SS_STAT_ADDR) begin
      rdata_r <= stat;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_unpack
      assign rise_a[gi] = RISE_POS[gi*W +: W];
      assign fall_a[gi] = FALL_POS[gi*W +: W];
      assign gap[gi] = gap_of(rise_a[gi], fall_a[gi], SW_PERIOD);
    end
  endgenerate

  // Reference variations for the two groups
  always_comb begin
    v2 = cfg_r.d2_period_mode ? sat_sub(SW_PERIOD, rise_a[`SS_IDX_D2]) // R6
                              : gap[`SS_IDX_D2]; // R6
    if (cfg_r.global_var) begin
      v_odd = v2; // R4
      v_even = v2; // R4
    end else begin
      v_odd = cfg_r.odd_sel ? gap[`SS_IDX_D3] : gap[`SS_IDX_D1]; // R5 R7
      v_even = cfg_r.even_sel ? gap[`SS_IDX_D4] : v2; // R5 R8
    end
  end

  assign rif.period = SW_PERIOD;
  assign rif.limit = (v_odd > v_even) ? v_odd : v_even; // R9
  assign rif.rate = cfg_r.rate; // R3
  assign rif.start = SS_START;

  // Once the ramp reaches the limit nothing is removed any more
  assign shrink_odd = rif.active ? sat_sub(v_odd, rif.ramp) : '0; // R9
  assign shrink_even = rif.active ? sat_sub(v_even, rif.ramp) : '0; // R9

  // The first edge stays put; the edge that follows it moves
  always_comb begin
    logic [W-1:0] sh;
    logic [W-1:0] red;
    logic fall_after;
    sh = '0;
    red = '0;
    fall_after = 1'b1;
    for (int i = 0; i < N; i++) begin
      sh = ODD_MASK[i] ? shrink_odd : shrink_even; // R5
      red = sat_sub(gap[i], sh); // R3
      if (cfg_r.edge_a) begin
        fall_after = GRP_A_MASK[i] ? 1'b1 : cfg_r.edge_b_fall; // R1 R2
      end else begin
        fall_after = (fall_a[i] >= rise_a[i]);
      end
      if (fall_after) begin
        eff_rise_nxt[i] = rise_a[i];
        eff_fall_nxt[i] = wrap_add(rise_a[i], red, SW_PERIOD); // R1 R2
      end else begin
        eff_fall_nxt[i] = fall_a[i];
        eff_rise_nxt[i] = wrap_sub(fall_a[i], red, SW_PERIOD); // R2
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < N; i++) begin
        eff_rise_r[i] <= '0;
        eff_fall_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        eff_rise_r[i] <= eff_rise_nxt[i];
        eff_fall_r[i] <= eff_fall_nxt[i];
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      run_r <= 1'b0;
    end else begin
      run_r <= rif.active || rif.done;
    end
  end

  ss_ramp #(.W(W)) u_ramp (
    .clk(MCLK),
    .rst(RST),
    .rif(rif)
  );

  generate
    for (gi = 0; gi < N; gi++) begin : g_edge
      ss_edge #(.W(W)) u_edge (
        .clk(MCLK),
        .rst(RST),
        .run(run_r),
        .phase(rif.phase),
        .rise(eff_rise_r[gi]),
        .fall(eff_fall_r[gi]),
        .drive(PWM_DRIVE[gi])
      );
    end
  endgenerate

  assign REG_RDATA = rdata_r;
  assign SS_ACTIVE = rif.active;
  assign SS_DONE = rif.done;
endmodule : ss_fixed_duty_soft_start

// File: rtl/ss_pkg.sv
// Types shared by the soft-start block.
// Field order of cfg_t matches the 8-bit configuration register.
package ss_pkg;
  typedef logic [1:0] rate_t;

  typedef struct packed {
    logic edge_a;
    logic edge_b_fall;
    rate_t rate;
    logic global_var;
    logic d2_period_mode;
    logic odd_sel;
    logic even_sel;
  } cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_HOLD = 2'b10
  } ramp_state_t;
endpackage : ss_pkg

// File: rtl/ss_ramp.sv
// Switching-cycle timer and soft-start ramp sequencer.
// Assumes period, limit and rate are stable while a ramp runs.
`timescale 1ns/1ps
`include "ss_defines.svh"
module ss_ramp #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sequencer bundle
  ramp_if.ctrl rif
);
  import ss_pkg::*;

  ramp_state_t state_r;
  logic [W-1:0] phase_r;
  logic [W-1:0] ramp_r;
  logic [3:0] div_cnt_r;
  logic active_r;
  logic done_r;
  logic [W-1:0] period_m1;
  logic wrap;
  logic [3:0] div_last;
  logic [W:0] ramp_sum;
  logic [W-1:0] step;

  // A zero period would never wrap; treat it as one tick
  assign period_m1 = (rif.period == '0) ? '0 : rif.period - W'(1);
  assign wrap = (phase_r >= period_m1);
  assign div_last = 4'((4'h1 << rif.rate) - 4'h1); // R3
  assign step = W'(`SS_STEP_TICKS); // R3
  assign ramp_sum = {1'b0, ramp_r} + {1'b0, step};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= '0;
    end else if (wrap) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ramp_r <= '0;
      div_cnt_r <= 4'h0;
    end else if (rif.start) begin
      state_r <= ST_RAMP; // R9
      ramp_r <= '0;
      div_cnt_r <= 4'h0;
    end else begin
      case (state_r)
        ST_RAMP: begin
          if (ramp_r >= rif.limit) begin
            state_r <= ST_HOLD; // R9
          end else if (wrap) begin
            if (div_cnt_r >= div_last) begin
              div_cnt_r <= 4'h0;
              ramp_r <= (ramp_sum >= {1'b0, rif.limit}) ? rif.limit : ramp_sum[W-1:0]; // R3
            end else begin
              div_cnt_r <= div_cnt_r + 4'h1; // R3
            end
          end
        end
        ST_HOLD: begin
          state_r <= ST_HOLD;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      active_r <= rif.start || ((state_r == ST_RAMP) && (ramp_r < rif.limit));
      done_r <= !rif.start && ((state_r == ST_HOLD) ||
                               ((state_r == ST_RAMP) && (ramp_r >= rif.limit)));
    end
  end

  assign rif.phase = phase_r;
  assign rif.cycle_end = wrap;
  assign rif.ramp = ramp_r;
  assign rif.active = active_r;
  assign rif.done = done_r;
endmodule : ss_ramp

// File: sim/power_stage_model.sv
// Power stage stand-in: logs when each gate drive turns on and off.
// Assumes the drives change on the rising clock edge.
`timescale 1ns/1ps
module power_stage_model (
  // Clock
  input wire logic clk,
  // Gate drives
  input wire logic [7:0] gate,
  // Tick of last turn-on and turn-off
  output int rise_t [8],
  output int fall_t [8]
);
  int now = 0;
  logic [7:0] gate_q = 8'h00;
  always @(posedge clk) begin
    now <= now + 1;
    gate_q <= gate;
    for (int i = 0; i < 8; i++) begin
      if (gate[i] && !gate_q[i]) rise_t[i] <= now;
      if (!gate[i] && gate_q[i]) fall_t[i] <= now;
    end
  end
endmodule : power_stage_model

// File: sim/ss_fixed_duty_soft_start_tb.sv
// Bench for the fixed-duty soft-start block.
// Assumes a 20-tick period and the power stage model on the drives.
`timescale 1ns/1ps
`include "ss_defines.svh"
module ss_fixed_duty_soft_start_tb;
  import ss_pkg::*;
  localparam int W = 16;
  localparam int P = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic start = 1'b0;
  logic [W-1:0] period = 16'h0014;
  // Gaps 8, 4, 12, 16 on drives 1..4, repeated on 5..8
  logic [8*W-1:0] rise_pos = {2{16'h0002, 16'h0004, 16'h0000, 16'h0002}};
  logic [8*W-1:0] fall_pos = {2{16'h0012, 16'h0010, 16'h0004, 16'h000A}};
  logic [7:0] rdata;
  logic [7:0] drive;
  logic active;
  logic done;
  logic [7:0] v;
  int rise_t [8];
  int fall_t [8];
  int n_fail = 0;
  int checks = 0;
  int n, r1, r3, f3;
  logic [7:0] cfgs [9] = '{8'h00, 8'h02, 8'h01, 8'h04, 8'h0B, 8'h0F, 8'h10, 8'h20, 8'h30};
  int ks [9] = '{2, 3, 4, 5, 1, 5, 4, 8, 16};

  always #5 mclk = ~mclk;

  ss_fixed_duty_soft_start #(.W(W)) ss_fixed_duty_soft_start_i (.MCLK(mclk), .RST(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .SW_PERIOD(period), .RISE_POS(rise_pos), .FALL_POS(fall_pos), .SS_START(start),
    .PWM_DRIVE(drive), .SS_ACTIVE(active), .SS_DONE(done));
  power_stage_model power_stage_model_i (.clk(mclk), .gate(drive), .rise_t(rise_t),
    .fall_t(fall_t));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
    @(posedge mclk);
  endtask : rd_reg
  task automatic ramp(input logic [7:0] c);
    wr_reg(`SS_CFG_ADDR, c);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    n = 0;
    // Done of the previous ramp still shows in the start edge's time step
    do begin
      @(negedge mclk);
      n++;
    end while (done !== 1'b1 && n < 2000);
    @(posedge mclk);
  endtask : ramp
  task automatic results();
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    results();
  end

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd_reg(`SS_CFG_ADDR, v);
    chk(v, `SS_CFG_RESET, "config reset");
    wr_reg(`SS_CFG_ADDR, 8'hA5);
    rd_reg(`SS_CFG_ADDR, v);
    chk(v, 8'hA5, "config");
    wr_reg(`SS_STAT_ADDR, 8'hFF);
    rd_reg(`SS_STAT_ADDR, v);
    chk(v, 8'h00, "status idle");
    rd_reg(16'h1234, v);
    chk(v, 8'h00, "unmapped");
    chk(drive, 8'h00, "drives before start");
    for (int i = 0; i < 9; i++) begin
      ramp(cfgs[i]);
      chk(n >= (ks[i] - 1) * P && n <= ks[i] * P + 8, 1, "ramp length");
      repeat (P) @(posedge mclk);
      rd_reg(`SS_STAT_ADDR, v);
      chk(v, 8'h02, "status done");
    end
    // Kept edge keeps its phase; the other one moves while the ramp is short
    for (int b = 0; b < 2; b++) begin
      wr_reg(`SS_CFG_ADDR, b ? 8'hF0 : 8'hB0);
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      repeat (12 * P) @(negedge mclk);
      r1 = rise_t[0];
      r3 = rise_t[2];
      f3 = fall_t[2];
      repeat (22 * P) @(negedge mclk);
      chk((rise_t[0] - r1) % P, 0, "drive 1 rise");
      chk((fall_t[2] - f3) % P != 0, b, "drive 3 fall moved");
      chk((rise_t[2] - r3) % P != 0, !b, "drive 3 rise moved");
      @(posedge mclk);
    end
    results();
  end
endmodule : ss_fixed_duty_soft_start_tb

// File: sim/ss_props.sv
// Port checker for the soft-start block.
// Assumes one clock and the register map of the defines header.
`timescale 1ns/1ps
`include "ss_defines.svh"
module ss_props (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Soft start
  input wire logic SS_START,
  input wire logic [7:0] PWM_DRIVE,
  input wire logic SS_ACTIVE,
  input wire logic SS_DONE
);
  import ss_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic started_r;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) started_r <= 1'b0;
    else if (SS_START) started_r <= 1'b1;
  end
  sequence s_cfg_wr; REG_WR && REG_ADDR == `SS_CFG_ADDR; endsequence
  sequence s_cfg_rd; REG_RD && REG_ADDR == `SS_CFG_ADDR; endsequence
  a_cfg_readback: assert property (s_cfg_wr ##1 s_cfg_rd |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("config read back differs");
  a_rdata_quiet: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data without strobe");
  a_unmapped_zero: assert property (REG_RD && REG_ADDR != `SS_CFG_ADDR
    && REG_ADDR != `SS_STAT_ADDR |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_status_flags: assert property (REG_RD && REG_ADDR == `SS_STAT_ADDR
    |=> REG_RDATA == {6'h00, $past(SS_DONE), $past(SS_ACTIVE)})
    else $error("status differs from flags");
  a_start_ramps: assert property (SS_START |=> SS_ACTIVE && !SS_DONE)
    else $error("start did not begin ramp");
  a_flags_excl: assert property (!(SS_ACTIVE && SS_DONE))
    else $error("active and done together");
  a_ramp_ends: assert property (SS_ACTIVE |=> SS_ACTIVE || SS_DONE)
    else $error("ramp stopped without done");
  a_done_holds: assert property (SS_DONE && !SS_START |=> SS_DONE)
    else $error("done dropped");
  a_done_cause: assert property ($rose(SS_DONE) |-> $past(SS_ACTIVE) && !SS_ACTIVE)
    else $error("done without ramp");
  a_quiet_idle: assert property (!started_r |-> PWM_DRIVE == 8'h00 && !SS_ACTIVE)
    else $error("drives before start");
endmodule : ss_props

bind ss_fixed_duty_soft_start ss_props ss_props_i (.MCLK(MCLK), .RST(RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .SS_START(SS_START), .PWM_DRIVE(PWM_DRIVE),
  .SS_ACTIVE(SS_ACTIVE), .SS_DONE(SS_DONE));
